// [vmss_save_engine.sv]
// Virtual machine interrupt state save engine
`timescale 1ns/1ns
`include "vmss_consts.svh"
module vmss_save_engine
	import vmss_pkg::*;
(
	input wire logic clk, // Clock, 20 MHz
	input wire logic reset, // Async reset, active high
	input wire logic req_write, // Write strobe of the save request register
	input wire vmss_pkg::vmss_vm_id_type save_target_machine_id, // Machine to save
	input wire logic save_trigger_bit, // Start a save
	input wire logic quiesce_check_bit, // Recheck quiesce status
	input wire logic any_resident, // A context of the target is resident
	input wire logic pending_change, // A pending state of the target changed
	input wire logic proc_count_change, // Valid processor count of the target changed
	input wire logic machine_valid, // Target machine is valid
	input wire logic msg_table_valid, // Message interrupt table valid for target
	input wire logic shr_table_valid, // Shared interrupt table valid for target
	input wire vmss_pkg::vmss_addr_type msg_table_base, // Message table base address
	input wire vmss_pkg::vmss_addr_type shr_table_base, // Shared table base address
	output vmss_pkg::vmss_vm_id_type state_vm_id, // Machine whose state is read
	output logic state_is_shared, // Read a shared interrupt state
	output vmss_pkg::vmss_intid_type state_intid, // Interrupt whose state is read
	input wire vmss_pkg::vmss_entry_type state_entry, // Live state and configuration, same cycle
	input wire logic live_change, // Live state of an interrupt of the target changed
	input wire logic live_change_shared, // That change was a shared interrupt
	input wire vmss_pkg::vmss_intid_type live_change_intid, // Interrupt that changed
	output logic mem_valid, // Table write request
	input wire logic mem_ready, // Table write accepted
	output vmss_pkg::vmss_addr_type mem_addr, // Table write address
	output vmss_pkg::vmss_entry_type mem_data, // Table write data
	output logic save_idle_flag, // Save complete
	output logic quiesced_flag // Machine stayed quiesced since trigger
);
	import vmss_pkg::*;

	vmss_state_type state_ff, nxt_state;
	vmss_vm_id_type vm_ff, nxt_vm;
	vmss_intid_type idx_ff, nxt_idx;
	logic shr_ff, nxt_shr;
	logic req_ff, nxt_req;
	vmss_addr_type addr_ff, nxt_addr;
	vmss_entry_type data_ff, nxt_data;
	logic idle_ff, nxt_idle;
	logic dirty_msg_ff, nxt_dirty_msg;
	logic mirror_ff, nxt_mirror;
	logic trigger;
	logic check;
	logic quiesced_now;

	function automatic vmss_addr_type entry_addr(input vmss_addr_type base, input vmss_intid_type idx);
		entry_addr = base + ({20'h00000, idx} * `VMSS_ENTRY_BYTES);
	endfunction

	function automatic logic last_index(input logic shared, input vmss_intid_type idx);
		last_index = shared ? (idx == `VMSS_SHR_COUNT - 12'h001) : (idx == `VMSS_MSG_COUNT - 12'h001);
	endfunction

	assign trigger = req_write && save_trigger_bit && idle_ff;
	assign check = req_write && quiesce_check_bit;

	vmss_quiesce_track u_track
	(
		.clk(clk),
		.reset(reset),
		.trigger(trigger),
		.check(check),
		.any_resident(any_resident),
		.pending_change(pending_change),
		.proc_count_change(proc_count_change),
		.machine_valid(machine_valid),
		.quiesced_now(quiesced_now),
		.quiesced_flag(quiesced_flag)
	);

	assign state_vm_id = vm_ff;
	assign state_is_shared = shr_ff;
	assign state_intid = idx_ff;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_vm = vm_ff;
		nxt_idx = idx_ff;
		nxt_shr = shr_ff;
		nxt_req = req_ff;
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		nxt_idle = idle_ff;
		nxt_dirty_msg = dirty_msg_ff;
		nxt_mirror = mirror_ff;
		case (state_ff)
			VMSS_IDLE:
			begin
				if (trigger)
				begin
					nxt_vm = save_target_machine_id;
					nxt_idle = 1'b0;
					nxt_idx = 12'h000;
					nxt_dirty_msg = 1'b0;
					nxt_mirror = quiesced_now;
					nxt_shr = !msg_table_valid;
					nxt_state = msg_table_valid ? VMSS_MSG : (shr_table_valid ? VMSS_SHR : VMSS_DONE);
				end
				else if (live_change && mirror_ff && quiesced_now && (live_change_shared ? shr_table_valid : msg_table_valid))
				begin
					// Mirror a quiesced-time change back into the table
					nxt_shr = live_change_shared;
					nxt_idx = live_change_intid;
					nxt_idle = 1'b0;
					nxt_state = live_change_shared ? VMSS_SHR : VMSS_MSG;
					nxt_dirty_msg = 1'b1;
				end
			end
			VMSS_MSG, VMSS_SHR:
			begin
				if (!req_ff)
				begin
					nxt_req = 1'b1;
					nxt_addr = entry_addr(shr_ff ? shr_table_base : msg_table_base, idx_ff);
					nxt_data = state_entry;
				end
				else if (mem_ready)
				begin
					nxt_req = 1'b0;
					nxt_idx = idx_ff + 12'h001;
					if (dirty_msg_ff || last_index(shr_ff, idx_ff))
					begin
						nxt_idx = 12'h000;
						if (!dirty_msg_ff && !shr_ff && shr_table_valid)
						begin
							nxt_shr = 1'b1;
							nxt_state = VMSS_SHR;
						end
						else
							nxt_state = VMSS_DONE;
					end
				end
			end
			VMSS_DONE:
			begin
				nxt_idle = 1'b1;
				nxt_dirty_msg = 1'b0;
				nxt_state = VMSS_IDLE;
			end
			default:
			begin
				nxt_state = VMSS_IDLE;
				nxt_idle = 1'b1;
				nxt_req = 1'b0;
			end
		endcase
		// Mirroring stops once the machine leaves quiescence, until the next trigger finds it quiesced
		if (!quiesced_now)
			nxt_mirror = 1'b0;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_ff <= VMSS_IDLE;
			vm_ff <= 16'h0000;
			idx_ff <= 12'h000;
			shr_ff <= 1'b0;
			req_ff <= 1'b0;
			addr_ff <= 32'h00000000;
			data_ff <= 32'h00000000;
			idle_ff <= `VMSS_IDLE_RESET;
			dirty_msg_ff <= 1'b0;
			mirror_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			vm_ff <= nxt_vm;
			idx_ff <= nxt_idx;
			shr_ff <= nxt_shr;
			req_ff <= nxt_req;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
			idle_ff <= nxt_idle;
			dirty_msg_ff <= nxt_dirty_msg;
			mirror_ff <= nxt_mirror;
		end
	end

	assign mem_valid = req_ff;
	assign mem_addr = addr_ff;
	assign mem_data = data_ff;
	assign save_idle_flag = idle_ff;

	sequence s_write_pending;
		mem_valid && !mem_ready;
	endsequence
	sequence s_write_hold;
		mem_valid && $stable(mem_addr) && $stable(mem_data);
	endsequence

	AST_IDLE_DROPS: assert property (@(posedge clk) disable iff (reset)
		trigger |=> !save_idle_flag)
		else $error("idle flag not cleared by trigger");
	AST_IDLE_LOW_WHILE_WRITING: assert property (@(posedge clk) disable iff (reset)
		mem_valid |-> !save_idle_flag)
		else $error("idle flag high during table write");
	AST_WRITE_HELD: assert property (@(posedge clk) disable iff (reset)
		s_write_pending |=> s_write_hold)
		else $error("table write dropped before acceptance");
	AST_NO_MSG_WHEN_INVALID: assert property (@(posedge clk) disable iff (reset)
		trigger && !msg_table_valid |=> state_ff != VMSS_MSG)
		else $error("write to absent message table");
	AST_EMPTY_SAVE_DONE: assert property (@(posedge clk) disable iff (reset)
		trigger && !msg_table_valid && !shr_table_valid |=> ##1 save_idle_flag)
		else $error("save without tables not completed in two cycles");
	AST_SAVE_STARTS: assert property (@(posedge clk) disable iff (reset)
		trigger && msg_table_valid |=> ##1 mem_valid && mem_addr == msg_table_base)
		else $error("save did not start at message table base");
	AST_DONE_SETS_IDLE: assert property (@(posedge clk) disable iff (reset)
		state_ff == VMSS_DONE |=> save_idle_flag)
		else $error("idle flag not set on completion");
	AST_QUIESCE_DEF: assert property (@(posedge clk) disable iff (reset)
		trigger && (any_resident || pending_change || proc_count_change || !machine_valid) |=> !quiesced_flag)
		else $error("quiesced reported while resident, changing or invalid");
	AST_NO_MIRROR_ABSENT_TABLE: assert property (@(posedge clk) disable iff (reset)
		state_ff == VMSS_IDLE && !trigger && live_change
		&& !(live_change_shared ? shr_table_valid : msg_table_valid) |=> save_idle_flag)
		else $error("entry mirrored into an absent table");
endmodule // vmss_save_engine

// [vmss_consts.svh]
// Constants for the virtual machine interrupt state save block
`ifndef VMSS_CONSTS_SVH
`define VMSS_CONSTS_SVH
`define VMSS_VM_ID_W 16
`define VMSS_INTID_W 12
`define VMSS_ENTRY_W 32
`define VMSS_ADDR_W 32
`define VMSS_MSG_COUNT 12'h040
`define VMSS_SHR_COUNT 12'h020
`define VMSS_ENTRY_BYTES 32'h00000004
`define VMSS_QUIESCE_RESET 1'b0
`define VMSS_IDLE_RESET 1'b1
`endif

// [vmss_pkg.sv]
// Types for the virtual machine interrupt state save block
`include "vmss_consts.svh"
package vmss_pkg;
	typedef logic [`VMSS_VM_ID_W-1:0] vmss_vm_id_type;
	typedef logic [`VMSS_INTID_W-1:0] vmss_intid_type;
	typedef logic [`VMSS_ENTRY_W-1:0] vmss_entry_type;
	typedef logic [`VMSS_ADDR_W-1:0] vmss_addr_type;
	typedef enum logic [3:0]
	{
		VMSS_IDLE = 4'b0001,
		VMSS_MSG = 4'b0010,
		VMSS_SHR = 4'b0100,
		VMSS_DONE = 4'b1000
	} vmss_state_type;
endpackage

// [vmss_quiesce_track.sv]
// Tracks whether the selected machine stayed quiesced since the last save trigger
`timescale 1ns/1ns
`include "vmss_consts.svh"
module vmss_quiesce_track
	import vmss_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic reset, // Async reset, active high
	input wire logic trigger, // Save trigger accepted
	input wire logic check, // Quiesce check requested
	input wire logic any_resident, // A context of the machine is resident
	input wire logic pending_change, // A pending state of the machine changed
	input wire logic proc_count_change, // Valid processor count changed
	input wire logic machine_valid, // Machine is valid
	output logic quiesced_now, // Machine quiesced this cycle
	output logic quiesced_flag // Reported quiesce status
);
	import vmss_pkg::*;
	logic held_ff;
	logic nxt_held;
	logic flag_ff;
	logic nxt_flag;

	always_comb
	begin
		quiesced_now = !any_resident && !pending_change && !proc_count_change && machine_valid;
		nxt_held = held_ff;
		nxt_flag = flag_ff;
		if (trigger)
			nxt_held = quiesced_now;
		else if (!quiesced_now)
			nxt_held = 1'b0;
		if (trigger || check)
			nxt_flag = trigger ? quiesced_now : (held_ff && quiesced_now);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			held_ff <= `VMSS_QUIESCE_RESET;
			flag_ff <= `VMSS_QUIESCE_RESET;
		end
		else
		begin
			held_ff <= nxt_held;
			flag_ff <= nxt_flag;
		end
	end

	assign quiesced_flag = flag_ff;

	AST_FLAG_AFTER_CHECK: assert property (@(posedge clk) disable iff (reset)
		check && !trigger && !held_ff |=> !quiesced_flag)
		else $error("quiesced flag set after check with broken quiesce");
	AST_FLAG_TRIGGER: assert property (@(posedge clk) disable iff (reset)
		trigger |=> quiesced_flag == $past(quiesced_now))
		else $error("quiesced flag not loaded on trigger");
endmodule // vmss_quiesce_track

// [vmss_save_engine_test.sv]
// Self-checking testbench for the virtual machine interrupt state save engine
`timescale 1ns/1ns
`include "vmss_consts.svh"
module vmss_save_engine_test;
	import vmss_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic req_write = 1'b0;
	vmss_vm_id_type vm_id = 16'h0000;
	logic trig_bit = 1'b0;
	logic chk_bit = 1'b0;
	logic any_resident = 1'b0;
	logic pending_change = 1'b0;
	logic proc_count_change = 1'b0;
	logic machine_valid = 1'b1;
	logic msg_valid = 1'b0;
	logic shr_valid = 1'b0;
	vmss_addr_type msg_base = 32'h00001000;
	vmss_addr_type shr_base = 32'h00002000;
	vmss_vm_id_type state_vm_id;
	logic state_is_shared;
	vmss_intid_type state_intid;
	vmss_entry_type state_entry;
	logic live_change = 1'b0;
	logic live_shared = 1'b0;
	vmss_intid_type live_intid = 12'h000;
	logic mem_valid;
	logic mem_ready = 1'b0;
	vmss_addr_type mem_addr;
	vmss_entry_type mem_data;
	logic save_idle_flag;
	logic quiesced_flag;
	logic [63:0] exp_q[$];
	logic [63:0] note;
	vmss_entry_type copy_q[$];
	logic one_of_n_support_flag = 1'b1;
	logic table_metadata_support_flag = 1'b1;
	localparam int PEND_BIT = 28;
	int n_fail = 0;
	int checks_done = 0;
	integer seed = 80894;

	// Live state answer encodes which entry was looked up; bit 28 models pending, bits 30:29 metadata
	assign state_entry = {state_is_shared, 2'h0, state_intid[0] ^ state_vm_id[0], state_intid, state_vm_id};

	vmss_save_engine i_dut (.clk(clk), .reset(reset), .req_write(req_write), .save_target_machine_id(vm_id),
		.save_trigger_bit(trig_bit), .quiesce_check_bit(chk_bit), .any_resident(any_resident),
		.pending_change(pending_change), .proc_count_change(proc_count_change), .machine_valid(machine_valid),
		.msg_table_valid(msg_valid), .shr_table_valid(shr_valid), .msg_table_base(msg_base),
		.shr_table_base(shr_base), .state_vm_id(state_vm_id), .state_is_shared(state_is_shared),
		.state_intid(state_intid), .state_entry(state_entry), .live_change(live_change),
		.live_change_shared(live_shared), .live_change_intid(live_intid), .mem_valid(mem_valid),
		.mem_ready(mem_ready), .mem_addr(mem_addr), .mem_data(mem_data), .save_idle_flag(save_idle_flag),
		.quiesced_flag(quiesced_flag));

	always #25 clk = ~clk;

	// Table writes are stalled at random
	always @(negedge clk)
		mem_ready <= (($random(seed) & 3) != 0);

	task automatic check_bit(string what, logic exp, logic got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_word(string what, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [63:0] mk(logic sh, vmss_intid_type id);
		return {(sh ? shr_base : msg_base) + {18'h0, id, 2'b00}, sh, 2'h0, id[0] ^ vm_id[0], id, vm_id};
	endfunction

	// Each accepted table write is matched against the oldest expected one
	always @(posedge clk)
		if (mem_valid === 1'b1 && mem_ready === 1'b1)
		begin
			note = (exp_q.size() > 0) ? exp_q.pop_front() : 64'h0;
			copy_q.push_back(mem_data);
			check_word("write address", note[63:32], mem_addr);
			check_word("write data", note[31:0], mem_data);
			check_bit("idle during write", 1'b0, save_idle_flag);
		end

	task automatic write_reg(logic t, logic c);
		@(negedge clk);
		req_write = 1'b1;
		trig_bit = t;
		chk_bit = c;
		@(negedge clk);
		req_write = 1'b0;
		trig_bit = 1'b0;
		chk_bit = 1'b0;
	endtask

	task automatic wait_idle();
		for (int i = 0; i < 3000 && save_idle_flag !== 1'b1; i++)
			@(negedge clk);
		check_bit("idle", 1'b1, save_idle_flag);
		check_word("writes left", 32'h0, exp_q.size());
	endtask

	task automatic run_save(logic m, logic s, logic again);
		copy_q.delete();
		msg_valid = m;
		shr_valid = s;
		vm_id = vmss_vm_id_type'($random(seed));
		for (int i = 0; i < `VMSS_MSG_COUNT && m; i++)
			exp_q.push_back(mk(1'b0, i[11:0]));
		for (int i = 0; i < `VMSS_SHR_COUNT && s; i++)
			exp_q.push_back(mk(1'b1, i[11:0]));
		write_reg(1'b1, 1'b0);
		check_bit("idle after trigger", 1'b0, save_idle_flag);
		if (again)
		begin
			repeat (10) @(negedge clk);
			vm_id = ~vm_id;
			write_reg(1'b1, 1'b0);
			vm_id = ~vm_id;
		end
		wait_idle();
		$display("test save %b%b%b done", m, s, again);
	endtask

	task automatic disturb(int k, logic v);
		case (k)
			0: any_resident = v;
			1: pending_change = v;
			2: proc_count_change = v;
			default: machine_valid = !v;
		endcase
	endtask

	task automatic live_update(logic sh, vmss_intid_type id, logic exp_write);
		if (exp_write)
			exp_q.push_back(mk(sh, id));
		live_shared = sh;
		live_intid = id;
		live_change = 1'b1;
		@(negedge clk);
		live_change = 1'b0;
		if (exp_write)
			wait_idle();
		else
			check_bit("no mirror write", 1'b1, save_idle_flag);
		$display("test live update %b %h done", sh, id);
	endtask

	// Software side of a migration: record pending entries, then clear pending and metadata in the copy
	task automatic migrate();
		int n_pend;
		n_pend = 0;
		check_word("copied entries", 32'h60, copy_q.size());
		foreach (copy_q[i])
		begin
			n_pend += copy_q[i][PEND_BIT];
			copy_q[i][PEND_BIT] = 1'b0;
			if (one_of_n_support_flag)
				copy_q[i][30:29] = 2'h0;
			if (table_metadata_support_flag)
				copy_q[i][30:29] = 2'h0;
		end
		check_word("recorded pending", 32'h30, n_pend);
		machine_valid = 1'b1;
		$display("test migrate done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#(50 * 40000);
		n_fail++;
		complete_run();
	end

	initial
	begin
		repeat (3) @(negedge clk);
		reset = 1'b0;
		check_bit("reset idle", `VMSS_IDLE_RESET, save_idle_flag);
		check_bit("reset quiesced", `VMSS_QUIESCE_RESET, quiesced_flag);
		check_bit("reset write", 1'b0, mem_valid);
		run_save(1'b1, 1'b1, 1'b0);
		migrate();
		live_update(1'b0, 12'h005, 1'b1);
		live_update(1'b1, 12'h01f, 1'b1);
		run_save(1'b1, 1'b0, 1'b1);
		run_save(1'b0, 1'b1, 1'b0);
		live_update(1'b0, 12'h007, 1'b0);
		run_save(1'b0, 1'b0, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			write_reg(1'b1, 1'b0);
			check_bit("quiesced at trigger", 1'b1, quiesced_flag);
			wait_idle();
			write_reg(1'b0, 1'b1);
			check_bit("quiesced on check", 1'b1, quiesced_flag);
			disturb(k, 1'b1);
			@(negedge clk);
			disturb(k, 1'b0);
			write_reg(1'b0, 1'b1);
			check_bit("disturbed since trigger", 1'b0, quiesced_flag);
			disturb(k, 1'b1);
			write_reg(1'b1, 1'b0);
			check_bit("trigger while disturbed", 1'b0, quiesced_flag);
			disturb(k, 1'b0);
			wait_idle();
			write_reg(1'b0, 1'b1);
			check_bit("check after disturbed trigger", 1'b0, quiesced_flag);
			$display("test quiesce %0d done", k);
		end
		// The last trigger saw a broken quiesce, so no change may be mirrored any more
		shr_valid = 1'b1;
		live_update(1'b1, 12'h003, 1'b0);
		complete_run();
	end
endmodule // vmss_save_engine_test
